// ===== include/rx_command_gain_control_defines.vh
`ifndef RX_COMMAND_GAIN_CONTROL_DEFINES_VH
`define RX_COMMAND_GAIN_CONTROL_DEFINES_VH
// Command byte framing, first two bits shifted in
`define RXC_HDR_BIT0 1'b1
`define RXC_HDR_BIT1 1'b0
// Device mode encoding for receive
`define RXC_MODE_RX 2'h2
`define RXC_MODE_OFF 2'h0
// Sub-command encodings
`define RXC_SUB_RESUME 2'h0
`define RXC_SUB_WAKE 2'h1
`define RXC_SUB_PREAMBLE 2'h2
`define RXC_SUB_FRAME 2'h3
// Gain-mode encodings
`define RXC_GAIN_KEEP 2'h0
`define RXC_GAIN_SWITCH 2'h1
`define RXC_GAIN_LOW 2'h2
`define RXC_GAIN_HIGH 2'h3
// Dynamic configuration set selectors
`define RXC_DCFG_ZERO 2'h0
`define RXC_DCFG_ONE 2'h1
`define RXC_DCFG_TWO 2'h2
// Local oscillator offset in kHz
`define RXC_LO_OFFSET_KHZ 16'h012C
// Bandgap settle time and clock rate
`define RXC_BANDGAP_NS 1000
`define RXC_CLK_MHZ 125
`define RXC_BANDGAP_CYCLES ((`RXC_BANDGAP_NS * `RXC_CLK_MHZ + 999) / 1000)
// Strength result width
`define RXC_STRENGTH_W 8
`endif

// ===== design/rx_pin_sync.v
`timescale 1ns/1ps
module rx_pin_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Raw and settled level
	input wire [W-1:0] raw_in,
	output reg [W-1:0] level_out
);
	reg [W-1:0] s1_reg;
	reg [W-1:0] s2_reg;
	reg [W-1:0] s3_reg;

	// Three stages; the level moves only once stages two and three agree
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			s1_reg <= {W{1'b0}};
			s2_reg <= {W{1'b0}};
			s3_reg <= {W{1'b0}};
			level_out <= {W{1'b0}};
		end else begin
			s1_reg <= raw_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_out <= level_out ^ ((s2_reg ~^ s3_reg) & (s2_reg ^ level_out));
		end
	end
endmodule // rx_pin_sync

// ===== design/rx_command_gain_control.v
// Operation
// - Above limit in wake search, drop gain
// - Reset gain starts at high setting
// - Low gain adds step compensation to strength
// - Receive mode enables synthesizer and receiver
// - Bandgap and cal clock on, wait 1us
// - Run calibration, stop its clock after
// - Wait synth lock, then receiver on
// - Command byte 1,0,freq,sub,gain fields
// - Local oscillator adds 300 kHz offset
// - Sub-band cal after transmit or freq change
// - Sub-command decode resume/wake/preamble/frame
// - Plain resume only routes receive lines
// - Idle resume starts nothing, routes output
// - Wake search restarts, set zero, high/low
// - Wake end samples status, applies follow-up
// - Preamble found switches to set two
// - Digitized outputs held, then clocked bits
// - Preamble timeout samples status, follow-up
// - Frame command uses set two directly
// - Frame reception ends only when stopped
// - Switch starts high, timer unaffected
// - Fourth bit sets mode and frequency
// - Eighth bit latches sub and gain
// - Command acts on next rising edge
`timescale 1ns/1ps
`include "rx_command_gain_control_defines.vh"
module rx_command_gain_control #(
	parameter BANDGAP_CYCLES = `RXC_BANDGAP_CYCLES,
	parameter SW = `RXC_STRENGTH_W
) (
	// Clock and reset
	input wire clk_in,
	input wire rstn_in,
	// Serial link pins
	input wire sclk_pin_in,
	input wire sdi_pin_in,
	input wire ref_clk_pin_in,
	output reg sclk_out,
	output reg sclk_oe_out,
	output reg sdo_out,
	output reg sdo_oe_out,
	// Link framing from the serial front end
	input wire cmd_start_in,
	input wire tx_command_in,
	input wire receiver_off_in,
	// Configuration
	input wire [7:0] gain_limit_reg_in,
	input wire [4:0] upper_gain_setting_in,
	input wire [3:0] reduced_gain_setting_in,
	input wire [6:0] gain_step_reg_in,
	input wire skip_filter_calibration_in,
	input wire digitized_output_in,
	input wire [1:0] wake_search_next_cfg_in,
	input wire [1:0] preamble_next_cfg_in,
	// Analog and recognition status
	input wire [SW-1:0] raw_strength_in,
	input wire filter_cal_done_in,
	input wire synth_locked_state_in,
	input wire wake_decided_in,
	input wire wake_found_in,
	input wire preamble_found_in,
	input wire preamble_timeout_in,
	input wire [1:0] detect_status_in,
	input wire rx_clock_in,
	input wire rx_data_in,
	input wire bit_strobe_in,
	// Control outputs
	output reg [1:0] device_operating_mode_out,
	output reg synth_enable_out,
	output reg receiver_enable_out,
	output reg receive_bandgap_on_out,
	output reg filter_cal_clock_on_out,
	output reg filter_cal_start_out,
	output reg receiver_on_out,
	output reg subband_cal_start_out,
	output reg [1:0] freq_set_out,
	output reg [15:0] lo_offset_khz_out,
	output reg [1:0] dyn_cfg_sel_out,
	output reg [4:0] receiver_gain_reg_out,
	output reg low_gain_active_out,
	output reg [SW-1:0] signal_strength_status_out,
	output reg [1:0] sampled_status_out,
	output reg [1:0] followup_cfg_out,
	output reg followup_valid_out,
	output reg [2:0] rx_phase_out
);
	// Receive phases, one-hot
	localparam PH_IDLE = 5'h01;
	localparam PH_WAKE = 5'h02;
	localparam PH_PREA = 5'h04;
	localparam PH_FRAME = 5'h08;
	localparam PH_DONE = 5'h10;
	// Start-up sequence, one-hot
	localparam SU_OFF = 5'h01;
	localparam SU_GAP = 5'h02;
	localparam SU_CAL = 5'h04;
	localparam SU_LOCK = 5'h08;
	localparam SU_ON = 5'h10;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	wire [2:0] pins_s;
	wire sclk_s = pins_s[0];
	wire sdi_s = pins_s[1];
	wire ref_s = pins_s[2];
	rx_pin_sync #(.W(3)) u_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.raw_in({ref_clk_pin_in, sdi_pin_in, sclk_pin_in}),
		.level_out(pins_s)
	);
	reg sclk_d_reg;
	reg ref_d_reg;
	wire sclk_rise = sclk_s & ~sclk_d_reg;
	wire sclk_fall = ~sclk_s & sclk_d_reg;
	wire ref_fall = ~ref_s & ref_d_reg;

	// Saturating add used for compensation
	function [SW-1:0] sat_add;
		input [SW-1:0] a;
		input [6:0] b;
		reg [SW:0] s;
		begin
			s = {1'b0, a} + {{(SW-6){1'b0}}, b};
			sat_add = s[SW] ? {SW{1'b1}} : s[SW-1:0];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Command shifter
	reg [3:0] bit_cnt_reg;
	reg [7:0] shift_reg;
	reg hdr_ok_reg;
	reg armed_reg;
	reg [1:0] sub_reg;
	reg [1:0] gain_reg;
	reg [1:0] prev_freq_reg;
	reg freq_valid_reg;
	reg freq_chg_reg;
	reg after_tx_reg;
	wire [7:0] shift_next = {shift_reg[6:0], sdi_s};

	// Bits sampled on falling serial clock edges, first bit first
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sclk_d_reg <= 1'b0;
			ref_d_reg <= 1'b0;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 8'h00;
			hdr_ok_reg <= 1'b0;
			armed_reg <= 1'b0;
			sub_reg <= `RXC_SUB_RESUME;
			gain_reg <= `RXC_GAIN_KEEP;
			prev_freq_reg <= 2'h0;
			freq_valid_reg <= 1'b0;
			freq_chg_reg <= 1'b0;
			after_tx_reg <= 1'b1;
			device_operating_mode_out <= `RXC_MODE_OFF;
			freq_set_out <= 2'h0;
			subband_cal_start_out <= 1'b0;
			lo_offset_khz_out <= 16'h0000;
		end else begin
			sclk_d_reg <= sclk_s;
			ref_d_reg <= ref_s;
			subband_cal_start_out <= 1'b0;
			if (tx_command_in) begin
				after_tx_reg <= 1'b1;
				lo_offset_khz_out <= 16'h0000;
			end
			if (receiver_off_in)
				device_operating_mode_out <= `RXC_MODE_OFF;
			if (cmd_start_in) begin
				bit_cnt_reg <= 4'h0;
				armed_reg <= 1'b0;
			end else if (sclk_fall && bit_cnt_reg < 4'h8) begin
				shift_reg <= shift_next;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (bit_cnt_reg == 4'h1)
					hdr_ok_reg <= (shift_reg[0] == `RXC_HDR_BIT0) && (sdi_s == `RXC_HDR_BIT1);
				if (bit_cnt_reg == 4'h3 && hdr_ok_reg) begin
					device_operating_mode_out <= `RXC_MODE_RX;
					freq_set_out <= shift_next[1:0];
					lo_offset_khz_out <= `RXC_LO_OFFSET_KHZ;
					prev_freq_reg <= shift_next[1:0];
					freq_valid_reg <= 1'b1;
					// Kept until the activating edge; the cal pulse is long gone by then
					freq_chg_reg <= !freq_valid_reg || prev_freq_reg != shift_next[1:0];
					// A transmit in the same cycle must still mark the next command
					after_tx_reg <= tx_command_in;
					if (after_tx_reg || !freq_valid_reg || prev_freq_reg != shift_next[1:0])
						subband_cal_start_out <= 1'b1;
				end
				if (bit_cnt_reg == 4'h7 && hdr_ok_reg) begin
					sub_reg <= shift_next[3:2];
					gain_reg <= shift_next[1:0];
					armed_reg <= 1'b1;
				end
			end else if (sclk_rise && armed_reg)
				armed_reg <= 1'b0;
		end
	end
	wire fire = sclk_rise & armed_reg;
	wire freq_same = ~freq_chg_reg;

	////////////////////////////////////////////////////////////////////////////
	// Start-up sequence driven by the reference clock falling edge
	reg [4:0] su_reg;
	reg [15:0] gap_cnt_reg;
	wire rx_mode = device_operating_mode_out == `RXC_MODE_RX;

	// Calibration clock runs only between its two falling reference edges
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			su_reg <= SU_OFF;
			gap_cnt_reg <= 16'h0000;
			synth_enable_out <= 1'b0;
			receiver_enable_out <= 1'b0;
			receive_bandgap_on_out <= 1'b0;
			filter_cal_clock_on_out <= 1'b0;
			filter_cal_start_out <= 1'b0;
			receiver_on_out <= 1'b0;
		end else begin
			synth_enable_out <= rx_mode;
			receiver_enable_out <= rx_mode;
			filter_cal_start_out <= 1'b0;
			if (!rx_mode) begin
				su_reg <= SU_OFF;
				receive_bandgap_on_out <= 1'b0;
				filter_cal_clock_on_out <= 1'b0;
				receiver_on_out <= 1'b0;
			end else begin
				case (su_reg)
				SU_OFF: if (ref_fall) begin
					receive_bandgap_on_out <= 1'b1;
					filter_cal_clock_on_out <= ~skip_filter_calibration_in;
					gap_cnt_reg <= 16'h0000;
					su_reg <= SU_GAP;
				end
				SU_GAP: if (gap_cnt_reg >= BANDGAP_CYCLES[15:0] - 16'h0001) begin
					if (filter_cal_clock_on_out) begin
						filter_cal_start_out <= 1'b1;
						su_reg <= SU_CAL;
					end else
						su_reg <= SU_LOCK;
				end else
					gap_cnt_reg <= gap_cnt_reg + 16'h0001;
				SU_CAL: if (filter_cal_done_in && ref_fall) begin
					filter_cal_clock_on_out <= 1'b0;
					su_reg <= SU_LOCK;
				end
				SU_LOCK: if (synth_locked_state_in) begin
					receiver_on_out <= 1'b1;
					su_reg <= SU_ON;
				end
				SU_ON: su_reg <= SU_ON;
				default: su_reg <= SU_OFF;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive phase machine and gain control
	reg [4:0] ph_reg;
	reg switch_mode_reg;
	reg [1:0] eff_gain;
	wire receiving = ph_reg != PH_IDLE && ph_reg != PH_DONE;
	wire restart = fire && sub_reg != `RXC_SUB_RESUME;

	// Gain-mode 01 collapses to keep outside wake search
	always @* begin
		eff_gain = gain_reg;
		if (gain_reg == `RXC_GAIN_SWITCH && sub_reg != `RXC_SUB_WAKE)
			eff_gain = `RXC_GAIN_KEEP;
	end

	// Restarting commands win over any phase in progress
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ph_reg <= PH_IDLE;
			switch_mode_reg <= 1'b0;
			dyn_cfg_sel_out <= `RXC_DCFG_ZERO;
			receiver_gain_reg_out <= 5'h00;
			low_gain_active_out <= 1'b0;
			sampled_status_out <= 2'h0;
			followup_cfg_out <= 2'h0;
			followup_valid_out <= 1'b0;
			signal_strength_status_out <= {SW{1'b0}};
			rx_phase_out <= 3'h0;
		end else begin
			followup_valid_out <= 1'b0;
			if (ph_reg == PH_IDLE && !receiving && !fire && !low_gain_active_out)
				receiver_gain_reg_out <= upper_gain_setting_in;
			if (tx_command_in || receiver_off_in || !rx_mode) begin
				ph_reg <= PH_IDLE;
				switch_mode_reg <= 1'b0;
			end else if (restart) begin
				case (sub_reg)
				`RXC_SUB_WAKE: begin
					ph_reg <= PH_WAKE;
					dyn_cfg_sel_out <= `RXC_DCFG_ZERO;
				end
				`RXC_SUB_PREAMBLE: begin
					ph_reg <= PH_PREA;
					dyn_cfg_sel_out <= `RXC_DCFG_ONE;
				end
				default: begin
					ph_reg <= PH_FRAME;
					dyn_cfg_sel_out <= `RXC_DCFG_TWO;
				end
				endcase
				switch_mode_reg <= eff_gain == `RXC_GAIN_SWITCH;
				if (eff_gain == `RXC_GAIN_LOW) begin
					receiver_gain_reg_out <= {1'b0, reduced_gain_setting_in};
					low_gain_active_out <= 1'b1;
				end else if (eff_gain == `RXC_GAIN_HIGH || eff_gain == `RXC_GAIN_SWITCH) begin
					receiver_gain_reg_out <= upper_gain_setting_in;
					low_gain_active_out <= 1'b0;
				end
			end else begin
				case (ph_reg)
				PH_WAKE: begin
					// Switch does not touch the wake timer, which lives outside
					if (switch_mode_reg && !low_gain_active_out &&
						raw_strength_in > gain_limit_reg_in[SW-1:0]) begin
						receiver_gain_reg_out <= {1'b0, reduced_gain_setting_in};
						low_gain_active_out <= 1'b1;
					end
					if (wake_decided_in) begin
						sampled_status_out <= detect_status_in;
						followup_cfg_out <= wake_search_next_cfg_in;
						followup_valid_out <= 1'b1;
						ph_reg <= PH_DONE;
					end
				end
				PH_PREA: if (preamble_found_in) begin
					sampled_status_out <= detect_status_in;
					dyn_cfg_sel_out <= `RXC_DCFG_TWO;
					ph_reg <= PH_FRAME;
				end else if (preamble_timeout_in) begin
					sampled_status_out <= detect_status_in;
					followup_cfg_out <= preamble_next_cfg_in;
					followup_valid_out <= 1'b1;
					ph_reg <= PH_DONE;
				end
				PH_FRAME: ph_reg <= PH_FRAME;
				PH_IDLE: ph_reg <= PH_IDLE;
				PH_DONE: ph_reg <= PH_DONE;
				default: ph_reg <= PH_IDLE;
				endcase
			end
			// Compensated strength keeps the reading continuous across gain steps
			signal_strength_status_out <= low_gain_active_out ?
				sat_add(raw_strength_in, gain_step_reg_in) : raw_strength_in;
			rx_phase_out <= {ph_reg == PH_FRAME, ph_reg == PH_PREA, ph_reg == PH_WAKE};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial line routing
	reg route_reg;
	reg bit_reg;

	// Lines are handed back when a new command byte starts
	always @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			route_reg <= 1'b0;
			bit_reg <= 1'b0;
			sclk_out <= 1'b0;
			sclk_oe_out <= 1'b0;
			sdo_out <= 1'b0;
			sdo_oe_out <= 1'b0;
		end else begin
			if (cmd_start_in || tx_command_in)
				route_reg <= 1'b0;
			else if (fire && (sub_reg != `RXC_SUB_RESUME || freq_same || !receiving))
				route_reg <= 1'b1;
			if (bit_strobe_in)
				bit_reg <= rx_data_in;
			sclk_oe_out <= route_reg;
			sdo_oe_out <= route_reg;
			if (!digitized_output_in) begin
				sclk_out <= rx_clock_in;
				sdo_out <= rx_data_in;
			end else if (ph_reg == PH_WAKE) begin
				sclk_out <= 1'b1;
				sdo_out <= 1'b0;
			end else if (ph_reg == PH_PREA) begin
				sclk_out <= 1'b1;
				sdo_out <= 1'b1;
			end else if (ph_reg == PH_FRAME) begin
				sclk_out <= rx_clock_in;
				sdo_out <= bit_reg;
			end else begin
				sclk_out <= 1'b1;
				sdo_out <= 1'b0;
			end
		end
	end
endmodule // rx_command_gain_control

// ===== verif/rx_host_model.sv
`timescale 1ns/1ps
module rx_host_model (
	// Clock
	input wire clk_in,
	// Link pins toward the device
	output logic host_sclk_out,
	output logic host_sdi_out,
	output logic host_start_out
);
	//////////////////////////////////////////////////////////////////////
	// Idle link: clock stands low between frames
	initial begin
		host_sclk_out = 1'b0;
		host_sdi_out = 1'b1;
		host_start_out = 1'b0;
	end
	// One command byte, first bit first; data moves as the clock rises
	task automatic send(input logic [7:0] b);
		int i;
		@(posedge clk_in);
		#1 host_start_out = 1'b1;
		@(posedge clk_in);
		#1 host_start_out = 1'b0;
		for (i = 7; i >= 0; i--) begin
			host_sdi_out = b[i];
			host_sclk_out = 1'b1;
			repeat (6) @(posedge clk_in);
			#1 host_sclk_out = 1'b0;
			repeat (6) @(posedge clk_in);
			#1;
		end
		// Released data line must not keep showing the last bit
		host_sdi_out = ~b[0];
		// Settle pause, then the activating rising edge
		repeat (10) @(posedge clk_in);
		#1 host_sclk_out = 1'b1;
		repeat (12) @(posedge clk_in);
		#1 host_sclk_out = 1'b0;
		repeat (8) @(posedge clk_in);
	endtask
endmodule // rx_host_model

// ===== verif/rx_command_gain_control_chk.sv
`timescale 1ns/1ps
module rxc_chk #(
	parameter SW = 8
) (
	// Clock, reset and watched inputs
	input wire clk_in, rstn_in, digitized_output_in,
	input wire wake_decided_in, preamble_found_in, preamble_timeout_in,
	input wire [1:0] wake_search_next_cfg_in, preamble_next_cfg_in,
	input wire [3:0] reduced_gain_setting_in,
	input wire [6:0] gain_step_reg_in,
	input wire [SW-1:0] raw_strength_in, signal_strength_status_out,
	// Watched outputs
	input wire sclk_out, sclk_oe_out, sdo_out, synth_enable_out, receiver_enable_out,
	input wire low_gain_active_out, followup_valid_out,
	input wire [1:0] device_operating_mode_out, followup_cfg_out, dyn_cfg_sel_out,
	input wire [4:0] receiver_gain_reg_out,
	input wire [2:0] rx_phase_out
);
	//////////////////////////////////////////////////////////////////////
	// Expected strength; saturates so a large step cannot wrap round
	wire [SW:0] sum_w = raw_strength_in + gain_step_reg_in;
	wire [SW-1:0] exp_w = !low_gain_active_out ? raw_strength_in :
		sum_w[SW] ? {SW{1'b1}} : sum_w[SW-1:0];
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Steps of the detection phases
	sequence wake_end_s;
		rx_phase_out == 3'h1 && wake_decided_in;
	endsequence
	sequence pre_hit_s;
		rx_phase_out == 3'h2 && preamble_found_in;
	endsequence
	sequence pre_miss_s;
		rx_phase_out == 3'h2 && preamble_timeout_in;
	endsequence
	//////////////////////////////////////////////////////////////////////
	AST_MODE_EN: assert property (
		device_operating_mode_out == 2'h2 |=> synth_enable_out && receiver_enable_out)
		else $error("enables missing in receive mode");
	AST_STEP: assert property (
		$past(rstn_in) |-> signal_strength_status_out == $past(exp_w))
		else $error("strength compensation wrong");
	AST_LOW_GAIN: assert property (
		$rose(low_gain_active_out) |-> receiver_gain_reg_out == {1'b0, reduced_gain_setting_in})
		else $error("low gain value wrong");
	AST_WAKE_END: assert property (
		wake_end_s |-> ##[1:2] followup_valid_out && followup_cfg_out == wake_search_next_cfg_in)
		else $error("wake search end follow-up missing");
	AST_PRE_HIT: assert property (
		pre_hit_s |-> ##[1:2] rx_phase_out == 3'h4 && dyn_cfg_sel_out == 2'h2)
		else $error("preamble found did not enter frame phase");
	AST_PRE_MISS: assert property (
		pre_miss_s |-> ##[1:2] followup_valid_out && followup_cfg_out == preamble_next_cfg_in)
		else $error("preamble timeout follow-up missing");
	AST_DCFG: assert property (
		rx_phase_out == 3'h1 && $stable(rx_phase_out) |-> dyn_cfg_sel_out == 2'h0)
		else $error("wake search config set wrong");
	AST_LINES: assert property (
		(rx_phase_out == 3'h1 || rx_phase_out == 3'h2) && $stable(rx_phase_out)
		&& sclk_oe_out && digitized_output_in |-> sclk_out && sdo_out == rx_phase_out[1])
		else $error("digitized line levels wrong");
endmodule // rxc_chk
bind rx_command_gain_control rxc_chk #(.SW(SW)) chk_u (.*);

// ===== verif/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
	$display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAIT(c) begin int k; k = 0; while ((c) !== 1'b1 && k < 3000) begin \
	@(posedge clk_in); #1 k++; end `CHK((c), 1'b1) if ((c) !== 1'b1) test_done(); end
module tb;
	// Design inputs, named after the ports
	logic clk_in = 1'b0, rstn_in = 1'b0, ref_clk_pin_in = 1'b0;
	logic tx_command_in = 1'b0, receiver_off_in = 1'b0, skip_filter_calibration_in = 1'b0;
	logic digitized_output_in = 1'b1, filter_cal_done_in = 1'b0, synth_locked_state_in = 1'b0;
	logic wake_decided_in = 1'b0, preamble_found_in = 1'b0, preamble_timeout_in = 1'b0;
	logic bit_strobe_in = 1'b0;
	logic [7:0] gain_limit_reg_in = 8'h00, raw_strength_in = 8'h00, lf = 8'h5E;
	logic [4:0] upper_gain_setting_in = 5'h00;
	logic [3:0] reduced_gain_setting_in = 4'h0;
	logic [6:0] gain_step_reg_in = 7'h00;
	logic [1:0] wake_search_next_cfg_in = 2'h0, preamble_next_cfg_in = 2'h0;
	logic [1:0] detect_status_in = 2'h0;
	wire sclk_pin_in, sdi_pin_in, cmd_start_in;
	// Design outputs
	wire sclk_out, sclk_oe_out, sdo_out, sdo_oe_out, synth_enable_out, receiver_enable_out;
	wire receive_bandgap_on_out, filter_cal_clock_on_out, filter_cal_start_out, receiver_on_out;
	wire subband_cal_start_out, low_gain_active_out, followup_valid_out;
	wire [1:0] device_operating_mode_out, freq_set_out, dyn_cfg_sel_out;
	wire [1:0] sampled_status_out, followup_cfg_out;
	wire [15:0] lo_offset_khz_out;
	wire [4:0] receiver_gain_reg_out;
	wire [7:0] signal_strength_status_out;
	wire [2:0] rx_phase_out;
	int mismatches = 0;
	int n_compared = 0;
	logic [3:0] note_q[$];
	logic [1:0] fs_q[$];
	//////////////////////////////////////////////////////////////////////
	rx_host_model host_u (.clk_in, .host_sclk_out(sclk_pin_in), .host_sdi_out(sdi_pin_in),
		.host_start_out(cmd_start_in));
	// Short bandgap count keeps the start-up walk brief
	rx_command_gain_control #(.BANDGAP_CYCLES(4)) dut_u (.*, .wake_found_in(1'b0),
		.rx_clock_in(ref_clk_pin_in), .rx_data_in(raw_strength_in[0]));
	// Clocks: reference pin is slow and free running
	initial forever #4 clk_in = ~clk_in;
	always begin
		repeat (5) @(posedge clk_in);
		#1 ref_clk_pin_in = ~ref_clk_pin_in;
	end
	//////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic cmd(input logic [1:0] f, s, g);
		host_u.send({2'b10, f, s, g});
		tick(4);
	endtask
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Result watcher: each pulse takes the oldest note; mid-cycle, away from the launch edge
	always @(negedge clk_in) begin
		if (followup_valid_out === 1'b1) begin
			`CHK(note_q.size() != 0, 1'b1)
			if (note_q.size() != 0) `CHK({sampled_status_out, followup_cfg_out}, note_q.pop_front())
		end
		if (subband_cal_start_out === 1'b1) begin
			`CHK(fs_q.size() != 0, 1'b1)
			if (fs_q.size() != 0) `CHK(freq_set_out, fs_q.pop_front())
		end
	end
	//////////////////////////////////////////////////////////////////////
	initial begin
		lf = lfsr(lf);
		gain_limit_reg_in = {2'h0, lf[5:0]} | 8'h01;
		upper_gain_setting_in = lf[4:0];
		lf = lfsr(lf);
		{reduced_gain_setting_in, wake_search_next_cfg_in, preamble_next_cfg_in} = lf;
		gain_step_reg_in = lfsr(lf);
		repeat (20) @(posedge clk_in);
		#1 rstn_in = 1'b1;
		tick(3);
		`CHK({device_operating_mode_out, receiver_gain_reg_out}, {2'h0, upper_gain_setting_in})
		$display("reset test done");
		// Start-up walk while the wake command with gain switching is sent
		fs_q.push_back(2'h1);
		fork
			cmd(2'h1, 2'h1, 2'h1);
			begin
				`WAIT(device_operating_mode_out == 2'h2)
				`CHK({lo_offset_khz_out, rx_phase_out}, {16'h012C, 3'h0})
				`WAIT(receive_bandgap_on_out && filter_cal_clock_on_out)
				`CHK(synth_enable_out & receiver_enable_out, 1'b1)
				`WAIT(filter_cal_start_out)
				filter_cal_done_in = 1'b1;
				`WAIT(!filter_cal_clock_on_out)
				`CHK(receiver_on_out, 1'b0)
				synth_locked_state_in = 1'b1;
				`WAIT(receiver_on_out)
			end
		join
		`CHK({rx_phase_out, dyn_cfg_sel_out}, {3'h1, 2'h0})
		`CHK({sclk_oe_out, sclk_out, sdo_out}, 3'b110)
		`CHK({low_gain_active_out, receiver_gain_reg_out}, {1'b0, upper_gain_setting_in})
		raw_strength_in = gain_limit_reg_in + 8'h01 + lf[4:0];
		`WAIT(low_gain_active_out)
		`CHK({rx_phase_out, receiver_gain_reg_out}, {3'h1, 1'b0, reduced_gain_setting_in})
		tick(2);
		`CHK(signal_strength_status_out, raw_strength_in + gain_step_reg_in)
		detect_status_in = lf[7:6];
		note_q.push_back({detect_status_in, wake_search_next_cfg_in});
		pulse(wake_decided_in);
		tick(4);
		$display("wake test done");
		// Preamble: timeout with gain kept, then found with high gain
		for (int i = 0; i < 2; i++) begin
			cmd(2'h1, 2'h2, {2{i[0]}});
			`CHK({rx_phase_out, dyn_cfg_sel_out, sclk_out, sdo_out}, {3'h2, 2'h1, 2'b11})
			`CHK(low_gain_active_out, !i[0])
			detect_status_in = ~detect_status_in;
			if (i == 0) note_q.push_back({detect_status_in, preamble_next_cfg_in});
			if (i == 0) pulse(preamble_timeout_in);
			else pulse(preamble_found_in);
			tick(4);
		end
		`CHK({rx_phase_out, dyn_cfg_sel_out}, {3'h4, 2'h2})
		tick(200);
		`CHK(rx_phase_out, 3'h4)
		// Digitized frame data holds the strobed bit; transparent shows it live
		raw_strength_in[0] = 1'b1;
		pulse(bit_strobe_in);
		raw_strength_in[0] = 1'b0;
		tick(2);
		`CHK(sdo_out, 1'b1)
		digitized_output_in = 1'b0;
		tick(2);
		`CHK(sdo_out, 1'b0)
		digitized_output_in = 1'b1;
		$display("preamble test done");
		// Frame with low gain and new frequency, then resume while active
		fs_q.push_back(2'h2);
		cmd(2'h2, 2'h3, 2'h2);
		`CHK({rx_phase_out, dyn_cfg_sel_out}, {3'h4, 2'h2})
		`CHK({low_gain_active_out, receiver_gain_reg_out}, {2'b10, reduced_gain_setting_in})
		cmd(2'h2, 2'h0, 2'h0);
		`CHK({rx_phase_out, sclk_oe_out}, {3'h4, 1'b1})
		// Resume with a new frequency during reception does not route the lines again
		fs_q.push_back(2'h3);
		cmd(2'h3, 2'h0, 2'h0);
		`CHK({rx_phase_out, sclk_oe_out}, {3'h4, 1'b0})
		// Transmit ends reception; idle resume only routes the lines
		pulse(tx_command_in);
		tick(3);
		`CHK({rx_phase_out, sclk_oe_out}, {3'h0, 1'b0})
		fs_q.push_back(2'h2);
		cmd(2'h2, 2'h0, 2'h0);
		`CHK({rx_phase_out, sclk_oe_out}, {3'h0, 1'b1})
		// Receiver off, then a byte with a wrong header
		pulse(receiver_off_in);
		tick(2);
		host_u.send(8'h64);
		tick(4);
		`CHK({device_operating_mode_out, rx_phase_out}, {2'h0, 3'h0})
		// Start-up again with calibration skipped: its clock stays off
		skip_filter_calibration_in = 1'b1;
		fork
			cmd(2'h2, 2'h1, 2'h0);
			begin
				`WAIT(receive_bandgap_on_out)
				`CHK(filter_cal_clock_on_out, 1'b0)
			end
		join
		`CHK({receiver_on_out, rx_phase_out}, {1'b1, 3'h1})
		$display("frame and resume test done");
		tick(10);
		`CHK(note_q.size() + fs_q.size(), 0)
		test_done();
	end
endmodule // tb
